// File: core/sys_ctrl.sv
// system control: interrupt entry/return, halt and wake, watchdog,
// indirect data-rom port and supply-monitor registers.
// assumes one clock, inputs synchronous to it, merged chip reset on resetn.
`timescale 1ns/10ps
`include "sys_ctrl_map.svh"
module sys_ctrl #(
   parameter int STAB_CYC = `SC_STAB_CYC,
   parameter int WDT_CYC = `SC_WDT_CYC,
   parameter int SAMPLE_CYC = `SC_SAMPLE_CYC
) (
   input wire logic clk_sys, // system clock
   input wire logic resetn, // merged chip reset, active low
   input wire logic [4:0] reg_addr, // special register address
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire sys_ctrl_pkg::nib_t reg_wdata, // write data nibble
   output sys_ctrl_pkg::nib_t reg_rdata_r, // read data, one cycle after strobe
   input wire sys_ctrl_pkg::cpu_ctx_s cpu_ctx, // live cpu context
   input wire logic op_halt, // halt executing
   input wire logic op_return_from_irq, // interrupt return executing
   input wire logic op_return_from_subroutine, // subroutine return executing
   output logic pc_load_r, // load program counter pulse
   output sys_ctrl_pkg::pc_t pc_load_val_r, // value to load
   output logic ctx_restore_r, // restore context pulse
   output sys_ctrl_pkg::cpu_ctx_s ctx_saved_r, // shadow context
   output logic cpu_stall_r, // cpu clock stopped
   output logic pwm_run_enable_r, // sample engine enable
   output logic pwm_load_r, // sample data load pulse
   input wire logic [3:0] port_a_pins, // port a input levels
   input wire logic [3:0] wake_pin_enable, // static wake option per pin
   input wire logic wdt_option, // static watchdog enable option
   output logic wdt_reset_r, // chip reset request pulse
   output logic [15:0] rom_addr_r, // data rom byte address
   input wire logic [7:0] rom_data, // data rom byte at rom_addr_r
   input wire logic supply_below, // detector comparator output
   output logic supply_monitor_on_r, // detector enable
   output sys_ctrl_pkg::nib_t level_sel_r // detector threshold code
);
   import sys_ctrl_pkg::*;

   localparam logic [13:0] STAB_LAST = 14'(STAB_CYC - 1);
   localparam logic [21:0] WDT_LAST = 22'(WDT_CYC - 1);
   localparam logic [9:0] SAMPLE_LAST = 10'(SAMPLE_CYC - 1);

   mode_e mode_r;
   logic [13:0] stab_cnt_r; // the default wait runs past 8191 cycles
   logic [21:0] wdt_cnt_r;
   logic [9:0] sample_cnt_r;
   logic [3:0] pins_last_r;
   logic global_irq_enable_r;
   logic pwm_request_flag_r;
   logic supply_low_flag_r;
   logic sample_tick;
   logic take_irq;
   logic wake_edge;
   logic wdt_clear;
   logic wr_status, wr_ctrl, wr_data_hi;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   assign wr_status = reg_wr && (reg_addr == `SC_OFS_STATUS);
   assign wr_ctrl = reg_wr && (reg_addr == `SC_OFS_PWM_CTRL);
   assign wr_data_hi = reg_wr && (reg_addr == `SC_OFS_DATA_HI);
   assign wake_edge = |(port_a_pins & ~pins_last_r & wake_pin_enable);
   // enable gates acceptance; halt and return take precedence
   assign take_irq = (mode_r == ST_RUN) && global_irq_enable_r && pwm_request_flag_r &&
                     !op_halt && !op_return_from_irq;
   assign sample_tick = pwm_run_enable_r && (sample_cnt_r == SAMPLE_LAST);
   assign wdt_clear = wr_data_hi || (mode_r != ST_RUN) || ((mode_r == ST_RUN) && op_halt);

   ////////////////////////////////////////////////////////////////////////////
   // port history for edge detection
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pins_last_r <= 4'h0;
      end else begin
         pins_last_r <= port_a_pins;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run / halt / stabilise; reset lands in the wait so reset beats wake
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_r <= ST_STAB;
         stab_cnt_r <= 14'h0000;
      end else begin
         case (mode_r)
            ST_RUN: begin
               if (op_halt) begin
                  mode_r <= ST_HALT;
               end
            end
            ST_HALT: begin
               stab_cnt_r <= 14'h0000;
               if (wake_edge) begin
                  mode_r <= ST_STAB;
               end
            end
            ST_STAB: begin
               if (stab_cnt_r == STAB_LAST) begin
                  mode_r <= ST_RUN;
                  stab_cnt_r <= 14'h0000;
               end else begin
                  stab_cnt_r <= stab_cnt_r + 14'h0001;
               end
            end
            default: begin
               mode_r <= ST_STAB;
               stab_cnt_r <= 14'h0000;
            end
         endcase
      end
   end

   // stall keeps the cpu from any ram write while halted
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpu_stall_r <= 1'b1;
      end else begin
         cpu_stall_r <= (mode_r == ST_RUN) ? op_halt :
                        !((mode_r == ST_STAB) && (stab_cnt_r == STAB_LAST));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter steering and context shadow
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pc_load_r <= 1'b0;
         pc_load_val_r <= `SC_VEC_RESET;
         ctx_restore_r <= 1'b0;
         ctx_saved_r <= '0;
      end else begin
         pc_load_r <= 1'b0;
         ctx_restore_r <= 1'b0;
         if ((mode_r == ST_RUN) && op_halt) begin
            pc_load_r <= 1'b1;
            pc_load_val_r <= `SC_VEC_WAKE;
         end else if ((mode_r == ST_RUN) && op_return_from_irq) begin
            pc_load_r <= 1'b1;
            pc_load_val_r <= ctx_saved_r.pc;
            ctx_restore_r <= 1'b1;
         end else if (take_irq) begin
            pc_load_r <= 1'b1;
            pc_load_val_r <= `SC_VEC_IRQ;
            ctx_saved_r <= cpu_ctx;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register: irq enable and sample engine enable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         global_irq_enable_r <= 1'b0;
         pwm_run_enable_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            global_irq_enable_r <= reg_wdata[`SC_BIT_IRQ_EN];
            pwm_run_enable_r <= reg_wdata[`SC_BIT_PWM_RUN];
         end
         // hardware updates override a same-cycle write
         if ((mode_r == ST_RUN) && op_halt) begin
            pwm_run_enable_r <= 1'b0; // halt stops the sample engine
         end else if ((mode_r == ST_RUN) && op_return_from_irq) begin
            global_irq_enable_r <= 1'b1;
         end else if (take_irq) begin
            global_irq_enable_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request flag: set wins over a same-cycle software clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pwm_request_flag_r <= 1'b0;
      end else begin
         if (sample_tick) begin
            pwm_request_flag_r <= 1'b1;
         end else if (wr_status) begin
            pwm_request_flag_r <= reg_wdata[`SC_BIT_PWM_FLAG];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sample_cnt_r <= 10'h000;
         pwm_load_r <= 1'b0;
      end else begin
         pwm_load_r <= sample_tick;
         if (!pwm_run_enable_r || sample_tick) begin
            sample_cnt_r <= 10'h000;
         end else begin
            sample_cnt_r <= sample_cnt_r + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog; length is a build-time figure, never a register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wdt_cnt_r <= 22'h000000;
         wdt_reset_r <= 1'b0;
      end else begin
         wdt_reset_r <= 1'b0;
         if (!wdt_option || wdt_clear) begin
            wdt_cnt_r <= 22'h000000;
         end else if (wdt_cnt_r == WDT_LAST) begin
            wdt_cnt_r <= 22'h000000;
            wdt_reset_r <= 1'b1;
         end else begin
            wdt_cnt_r <= wdt_cnt_r + 22'h000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rom address nibbles
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rom_addr_r <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_addr)
            `SC_OFS_ADDR0: rom_addr_r[3:0] <= reg_wdata;
            `SC_OFS_ADDR1: rom_addr_r[7:4] <= reg_wdata;
            `SC_OFS_ADDR2: rom_addr_r[11:8] <= reg_wdata;
            `SC_OFS_ADDR3: rom_addr_r[15:12] <= reg_wdata;
            default: rom_addr_r <= rom_addr_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // supply monitor registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         supply_monitor_on_r <= 1'b0;
         level_sel_r <= `SC_RST_LVD_SEL;
         supply_low_flag_r <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == `SC_OFS_LOW_VOLT_DETECT_CTRL)) begin
            supply_monitor_on_r <= reg_wdata[`SC_BIT_MON_ON];
         end
         // unused codes are stored as written; the detector ignores them
         if (reg_wr && (reg_addr == `SC_OFS_LVD_SEL)) begin
            level_sel_r <= reg_wdata;
         end
         supply_low_flag_r <= supply_monitor_on_r && supply_below;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, registered; unmapped offsets read zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_r <= 4'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `SC_OFS_STATUS: reg_rdata_r <= {1'b0, pwm_request_flag_r, cpu_ctx.carry, cpu_ctx.zero};
            `SC_OFS_PWM_CTRL: reg_rdata_r <= {2'b00, global_irq_enable_r, pwm_run_enable_r};
            `SC_OFS_LOW_VOLT_DETECT_CTRL: reg_rdata_r <= {2'b00, supply_low_flag_r, supply_monitor_on_r};
            `SC_OFS_LVD_SEL: reg_rdata_r <= level_sel_r;
            `SC_OFS_ADDR0: reg_rdata_r <= rom_addr_r[3:0];
            `SC_OFS_ADDR1: reg_rdata_r <= rom_addr_r[7:4];
            `SC_OFS_ADDR2: reg_rdata_r <= rom_addr_r[11:8];
            `SC_OFS_ADDR3: reg_rdata_r <= rom_addr_r[15:12];
            `SC_OFS_DATA_LO: reg_rdata_r <= rom_data[3:0];
            `SC_OFS_DATA_HI: reg_rdata_r <= rom_data[7:4];
            default: reg_rdata_r <= 4'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_halt_in;
      (mode_r == ST_RUN) && op_halt;
   endsequence
   sequence s_wake_done;
      (mode_r == ST_STAB) && (stab_cnt_r == STAB_LAST);
   endsequence

   irq_entry_vec_a: assert property (
      take_irq |=> pc_load_r && pc_load_val_r == `SC_VEC_IRQ && ctx_saved_r == $past(cpu_ctx))
      else $error("irq entry wrong");
   irq_enable_clr_a: assert property (
      take_irq |=> !global_irq_enable_r && pwm_request_flag_r)
      else $error("irq enable not cleared");
   irq_gate_a: assert property (
      pc_load_r && pc_load_val_r == `SC_VEC_IRQ && !ctx_restore_r |-> $past(global_irq_enable_r))
      else $error("irq taken while disabled");
   return_from_irq_restore_a: assert property (
      (mode_r == ST_RUN) && op_return_from_irq && !op_halt |=> ctx_restore_r && global_irq_enable_r
      && pc_load_val_r == ctx_saved_r.pc) else $error("return did not restore");
   return_from_subroutine_plain_a: assert property (
      (mode_r == ST_RUN) && op_return_from_subroutine && !op_return_from_irq && !take_irq |=> !ctx_restore_r)
      else $error("subroutine return restored");
   halt_vec_a: assert property (
      s_halt_in |=> pc_load_r && pc_load_val_r == `SC_VEC_WAKE && cpu_stall_r
      && mode_r == ST_HALT) else $error("halt entry wrong");
   wake_edge_a: assert property (
      (mode_r == ST_HALT) && wake_edge |=> mode_r == ST_STAB)
      else $error("wake edge ignored");
   stab_release_a: assert property (
      s_wake_done |=> !cpu_stall_r && mode_r == ST_RUN)
      else $error("stall not released");
   stab_hold_a: assert property (
      (mode_r == ST_STAB) && (stab_cnt_r != STAB_LAST) |=> cpu_stall_r)
      else $error("early release");
   wdt_kick_a: assert property (
      wr_data_hi |=> wdt_cnt_r == 22'h000000 && !wdt_reset_r)
      else $error("watchdog not cleared");
   wdt_fire_a: assert property (
      wdt_option && !wdt_clear && wdt_cnt_r == WDT_LAST |=> wdt_reset_r ##1 !wdt_reset_r)
      else $error("watchdog did not fire");
   wdt_off_a: assert property (
      !wdt_option |=> wdt_cnt_r == 22'h000000 && !wdt_reset_r)
      else $error("watchdog ran while off");
   flag_set_a: assert property (
      sample_tick |=> pwm_request_flag_r && pwm_load_r)
      else $error("request flag not set");
   rom_lo_a: assert property (
      reg_rd && reg_addr == `SC_OFS_DATA_LO |=> reg_rdata_r == $past(rom_data[3:0]))
      else $error("rom low nibble wrong");
   mon_flag_a: assert property (
      supply_monitor_on_r && supply_below |=> supply_low_flag_r)
      else $error("supply flag wrong");
   rom_hi_a: assert property (
      reg_rd && reg_addr == `SC_OFS_DATA_HI |=> reg_rdata_r == $past(rom_data[7:4]))
      else $error("rom high nibble wrong");
   addr_top_a: assert property (
      reg_wr && reg_addr == `SC_OFS_ADDR3 |=> rom_addr_r[15:12] == $past(reg_wdata))
      else $error("top address nibble wrong");
   mon_off_a: assert property (
      !supply_monitor_on_r |=> !supply_low_flag_r)
      else $error("flag set while monitor off");
   sel_write_a: assert property (
      reg_wr && reg_addr == `SC_OFS_LVD_SEL |=> level_sel_r == $past(reg_wdata))
      else $error("level select not stored");
   flag_hold_a: assert property (
      pwm_request_flag_r && !wr_status |=> pwm_request_flag_r)
      else $error("request flag dropped");
   halt_pwm_off_a: assert property (
      s_halt_in |=> !pwm_run_enable_r)
      else $error("sample engine ran on in halt");
   halt_wdt_clr_a: assert property (
      s_halt_in |=> wdt_cnt_r == 22'h000000)
      else $error("halt left watchdog running");
endmodule // sys_ctrl

// File: core/sys_ctrl_map.svh
// register offsets, field positions, reset values and timing counts of the
// system-control block; included by the block itself, not by the package.
`ifndef SYS_CTRL_MAP_SVH
`define SYS_CTRL_MAP_SVH
`define SC_OFS_STATUS 5'h00
`define SC_OFS_PWM_CTRL 5'h09
`define SC_OFS_LOW_VOLT_DETECT_CTRL 5'h13
`define SC_OFS_LVD_SEL 5'h14
`define SC_OFS_ADDR0 5'h18
`define SC_OFS_ADDR1 5'h19
`define SC_OFS_ADDR2 5'h1A
`define SC_OFS_ADDR3 5'h1B
`define SC_OFS_DATA_LO 5'h1C
`define SC_OFS_DATA_HI 5'h1D
`define SC_BIT_ZERO 0
`define SC_BIT_CARRY 1
`define SC_BIT_PWM_FLAG 2
`define SC_BIT_PWM_RUN 0
`define SC_BIT_IRQ_EN 1
`define SC_BIT_MON_ON 0
`define SC_BIT_MON_FLAG 1
`define SC_RST_LOW_VOLT_DETECT_CTRL 4'h0
`define SC_RST_LVD_SEL 4'hF
`define SC_LVL_1V6 4'h8
`define SC_LVL_2V8 4'hF
`define SC_LVL_3V8 4'h4
`define SC_VEC_RESET 13'h0000
`define SC_VEC_WAKE 13'h0004
`define SC_VEC_IRQ 13'h0008
`define SC_CLK_HZ 25000000
`define SC_CLK_NS 40
`define SC_SAMPLE_HZ 32768
`define SC_SAMPLE_CYC ((`SC_CLK_HZ + `SC_SAMPLE_HZ / 2) / `SC_SAMPLE_HZ)
`define SC_STAB_NS 352000
`define SC_STAB_CYC ((`SC_STAB_NS + `SC_CLK_NS - 1) / `SC_CLK_NS)
`define SC_WDT_MS 128
`define SC_WDT_CYC ((`SC_WDT_MS * 1000000) / `SC_CLK_NS)
`endif

// File: core/sys_ctrl_pkg.sv
// types shared by the system-control block and its neighbours.
// assumes the cpu core uses a 13-bit program counter.
package sys_ctrl_pkg;
   typedef logic [12:0] pc_t;
   typedef logic [3:0] nib_t;
   // context saved on interrupt entry, restored on interrupt return
   typedef struct packed {
      pc_t pc;
      nib_t code_page;
      nib_t ram_bank;
      logic carry;
      logic zero;
   } cpu_ctx_s;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_HALT = 3'b010,
      ST_STAB = 3'b100
   } mode_e;
endpackage

// File: tb/cpu_core_model.sv
// cpu core stand-in: advances the live context and obeys load/restore pulses.
// assumes the system-control block runs from the same clock and reset.
`timescale 1ns/10ps
module cpu_core_model
   import sys_ctrl_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic resetn, // chip reset, active low
   input wire logic stall, // cpu clock stopped
   input wire logic pc_load, // load pc pulse
   input wire sys_ctrl_pkg::pc_t pc_val, // value to load
   input wire logic restore, // restore context pulse
   input wire sys_ctrl_pkg::cpu_ctx_s saved, // shadow context
   output sys_ctrl_pkg::cpu_ctx_s ctx // live context
);
   ////////////////////////////////////////////////////////////////////////////
   // every field moves each running cycle, so a stale shadow copy shows up
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctx <= '0;
      end else if (restore) begin
         ctx <= saved;
      end else if (pc_load) begin
         ctx.pc <= pc_val;
      end else if (!stall) begin
         ctx <= {ctx.pc + 13'h1, ctx.code_page + 4'h1, ctx.ram_bank - 4'h3, ~ctx.carry,
            ctx.pc[0]};
      end
   end
endmodule // cpu_core_model

// File: tb/test_sys_ctrl.sv
// self-checking bench of the system-control block beside a cpu stand-in.
// assumes shortened stabilisation, watchdog and sample counts.
`timescale 1ns/10ps
module test_sys_ctrl;
   import sys_ctrl_pkg::*;
   localparam int STAB = 20;
   localparam int WDT = 50;
   localparam int SMP = 10;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, op_halt = 1'b0, op_return_from_irq = 1'b0, op_return_from_subroutine = 1'b0;
   nib_t reg_wdata = 4'h0, reg_rdata_r, level_sel_r;
   cpu_ctx_s cpu_ctx, ctx_saved_r, prev_ctx;
   logic pc_load_r, ctx_restore_r, cpu_stall_r, pwm_run_enable_r, pwm_load_r, wdt_reset_r;
   pc_t pc_load_val_r, m_pc;
   logic [3:0] port_a_pins = 4'h0, wake_pin_enable = 4'h0;
   logic wdt_option = 1'b0, supply_below = 1'b0, supply_monitor_on_r;
   logic [15:0] rom_addr_r;
   logic [7:0] rom_data, mb;
   logic [31:0] rng = 32'h765F;
   int n_fail = 0, total_checks = 0, cyc = 0, n_wdt = 0, i, k, cnt, ma;
   int m_addr [4];
   // bench data rom: byte derived from its address
   assign rom_data = rom_addr_r[7:0] ^ rom_addr_r[15:8] ^ 8'h5A;
   sys_ctrl #(.STAB_CYC(STAB), .WDT_CYC(WDT), .SAMPLE_CYC(SMP)) dut (.clk_sys(clk_sys),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .cpu_ctx(cpu_ctx),
      .op_halt(op_halt), .op_return_from_irq(op_return_from_irq), .op_return_from_subroutine(op_return_from_subroutine), .pc_load_r(pc_load_r),
      .pc_load_val_r(pc_load_val_r), .ctx_restore_r(ctx_restore_r),
      .ctx_saved_r(ctx_saved_r), .cpu_stall_r(cpu_stall_r),
      .pwm_run_enable_r(pwm_run_enable_r), .pwm_load_r(pwm_load_r),
      .port_a_pins(port_a_pins), .wake_pin_enable(wake_pin_enable),
      .wdt_option(wdt_option), .wdt_reset_r(wdt_reset_r), .rom_addr_r(rom_addr_r),
      .rom_data(rom_data), .supply_below(supply_below),
      .supply_monitor_on_r(supply_monitor_on_r), .level_sel_r(level_sel_r));
   cpu_core_model cpu (.clk_sys(clk_sys), .resetn(resetn), .stall(cpu_stall_r),
      .pc_load(pc_load_r), .pc_val(pc_load_val_r), .restore(ctx_restore_r),
      .saved(ctx_saved_r), .ctx(cpu_ctx));
   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, context history and watchdog pulse tally
   always @(posedge clk_sys) begin
      cyc++;
      prev_ctx <= cpu_ctx;
      if (wdt_reset_r === 1'b1) n_wdt++;
      if (cyc == 20000) begin
         n_fail++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // writes and reads are one-cycle strobes taken at the middle rising edge
   task automatic wr(logic [4:0] a, nib_t d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [4:0] a);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
   endtask
   task automatic rd_chk(string what, logic [4:0] a, nib_t exp);
      rd(a);
      total_checks++;
      if (reg_rdata_r !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, reg_rdata_r);
      end
   endtask
   task automatic pulse_op(int which);
      @(negedge clk_sys);
      if (which == 0) op_halt = 1'b1;
      else if (which == 1) op_return_from_irq = 1'b1;
      else op_return_from_subroutine = 1'b1;
      @(negedge clk_sys);
      {op_halt, op_return_from_irq, op_return_from_subroutine} = 3'b000;
   endtask
   // reset release followed by the stabilisation hold of the cpu
   task automatic release_chk;
      chk("pc_val", 0, pc_load_val_r);
      chk("level_sel", 4'hF, level_sel_r);
      resetn = 1'b1;
      repeat (STAB - 1) @(negedge clk_sys);
      chk("stall", 1, cpu_stall_r);
      repeat (3) @(negedge clk_sys);
      chk("stall", 0, cpu_stall_r);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk_sys);
      chk("mon_on", 0, supply_monitor_on_r);
      release_chk;
      rd_chk("low_volt_detect_ctrl", 5'h13, 4'h0);
      rd_chk("lvd_sel", 5'h14, 4'hF);
      $display("test reset done");
      // random rom addresses through the four nibble registers
      for (i = 0; i < 6; i++) begin
         for (k = 0; k < 4; k++) begin
            rng = xs(rng);
            m_addr[k] = rng[3:0];
            wr(5'h18 + 5'(k), rng[3:0]);
         end
         ma = ((m_addr[3] * 16 + m_addr[2]) * 16 + m_addr[1]) * 16 + m_addr[0];
         mb = ma[7:0] ^ ma[15:8] ^ 8'h5A;
         chk("rom_addr", ma[15:0], rom_addr_r);
         rd_chk("data_lo", 5'h1C, mb[3:0]);
         rd_chk("data_hi", 5'h1D, mb[7:4]);
      end
      rd_chk("unmapped", 5'h1E, 4'h0);
      for (i = 0; i < 16; i++) begin
         wr(5'h14, 4'(i));
         rd_chk("lvd_sel", 5'h14, 4'(i));
      end
      // flag bit is read-only and follows the comparator
      for (i = 0; i < 4; i++) begin
         supply_below = i[1] & i[0];
         wr(5'h13, {3'b111, i[0]});
         rd_chk("low_volt_detect_ctrl", 5'h13, {2'b00, supply_below, i[0]});
      end
      $display("test registers done");
      // sample spacing with the interrupt still masked
      wr(5'h09, 4'h1);
      for (k = 0; k < 4 * SMP && pwm_load_r !== 1'b1; k++) @(negedge clk_sys);
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while (pwm_load_r !== 1'b1 && k < 4 * SMP);
      chk("smp_period", SMP, k);
      wr(5'h09, 4'h3);
      for (k = 0; k < 4 * SMP && pc_load_r !== 1'b1; k++) @(negedge clk_sys);
      chk("irq_delay", 1, k);
      chk("irq_vec", 13'h008, pc_load_val_r);
      chk("ctx_saved", prev_ctx, ctx_saved_r);
      m_pc = prev_ctx.pc;
      rd(5'h09);
      chk("irq_en", 0, reg_rdata_r[1]);
      rd(5'h00);
      chk("req_flag", 1, reg_rdata_r[2]);
      cnt = 0;
      for (k = 0; k < 3 * SMP; k++) begin
         @(negedge clk_sys);
         if (pc_load_r === 1'b1) cnt++;
      end
      chk("nested", 0, cnt);
      wr(5'h09, 4'h0);
      wr(5'h00, 4'h0);
      pulse_op(2);
      chk("return_from_subroutine_load", 0, pc_load_r);
      pulse_op(1);
      chk("return_from_irq_load", 1, pc_load_r);
      chk("return_from_irq_pc", m_pc, pc_load_val_r);
      chk("restore", 1, ctx_restore_r);
      rd(5'h09);
      chk("irq_en", 1, reg_rdata_r[1]);
      wr(5'h09, 4'h1);
      chk("pwm_run", 1, pwm_run_enable_r);
      $display("test interrupt done");
      // halt, ignored pin, enabled pin wake
      wake_pin_enable = 4'h4;
      pulse_op(0);
      chk("halt_vec", {1'b1, 13'h004}, {pc_load_r, pc_load_val_r});
      chk("halt_stall", 1, cpu_stall_r);
      chk("halt_pwm", 0, pwm_run_enable_r);
      port_a_pins = 4'h2;
      repeat (STAB + 4) @(negedge clk_sys);
      chk("stall", 1, cpu_stall_r);
      port_a_pins = 4'h6;
      repeat (STAB) @(negedge clk_sys);
      chk("stall", 1, cpu_stall_r);
      @(negedge clk_sys);
      chk("stall", 0, cpu_stall_r);
      port_a_pins = 4'h0;
      pulse_op(0);
      resetn = 1'b0;
      @(negedge clk_sys);
      release_chk;
      $display("test halt done");
      wdt_option = 1'b1;
      cnt = n_wdt;
      for (i = 0; i < 6; i++) begin
         rng = xs(rng);
         wr(5'h1D, rng[3:0]);
         repeat (WDT / 2) @(negedge clk_sys);
      end
      chk("wdt_fed", cnt, n_wdt);
      wr(5'h1D, 4'h0);
      for (k = 1; k < WDT + 4 && wdt_reset_r !== 1'b1; k++) @(negedge clk_sys);
      chk("wdt_ovf", WDT + 1, k);
      resetn = 1'b0;
      wdt_option = 1'b0;
      repeat (2) @(negedge clk_sys);
      release_chk;
      cnt = n_wdt;
      repeat (2 * WDT) @(negedge clk_sys);
      chk("wdt_off", cnt, n_wdt);
      $display("test watchdog done");
      finish_test;
   end
endmodule // test_sys_ctrl
